// ---- rtl/ifm_regs.svh ----
// Constants for the programming-port mode control block
`ifndef IFM_REGS_SVH
`define IFM_REGS_SVH
// ==========================================
// Link commands
`define IFM_CMD_TEST_WR     8'hF0
`define IFM_CMD_TEST_RD     8'hF1
// ==========================================
// Field positions
`define IFM_CTL_MODE_BIT    7
`define IFM_STAT_MODE_BIT   7
`define IFM_STAT_PROT1_BIT  6
`define IFM_STAT_RWP_BIT    5
`define IFM_STAT_BUSY_BIT   3
`define IFM_TEST_BYPASS_BIT 2
// ==========================================
// Reset values and the test register write mask
`define IFM_CTL_RESET       8'h00
`define IFM_STAT_RESET      8'h00
`define IFM_TEST_RESET      8'h00
`define IFM_TEST_RD_MASK    8'h04
`endif

// ---- rtl/ifm_pkg.sv ----
// Types for the programming-port mode control block
package ifm_pkg;
  typedef enum logic [1:0] {
    IFM_IDLE,
    IFM_WR_DATA,
    IFM_RD_SEND
  } ifm_cmd_state_t;
endpackage

// ---- rtl/ifm_cmd_decode.sv ----
// Command decoder for test register access over the programming link
`timescale 1ns/1ps
`include "ifm_regs.svh"
module ifm_cmd_decode
  import ifm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  output logic            test_wr,
  output logic            test_rd,
  output logic [7:0]      wr_data
);
  ifm_cmd_state_t state_reg, state_next;
  logic           wr_reg, wr_next, rd_reg, rd_next;
  logic [7:0]     data_reg, data_next;

  always_comb begin
    state_next = state_reg;
    wr_next    = 1'b0;
    rd_next    = 1'b0;
    data_next  = data_reg;
    unique case (state_reg)
      IFM_IDLE: begin
        if (rx_valid && rx_byte == `IFM_CMD_TEST_WR) begin
          state_next = IFM_WR_DATA;
        end else if (rx_valid && rx_byte == `IFM_CMD_TEST_RD) begin
          rd_next = 1'b1;
        end
      end
      IFM_WR_DATA: begin
        if (rx_valid) begin
          wr_next    = 1'b1;
          data_next  = rx_byte;
          state_next = IFM_IDLE;
        end
      end
      default: begin
        state_next = IFM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= IFM_IDLE;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      data_reg  <= 8'h00;
    end else begin
      state_reg <= state_next;
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      data_reg  <= data_next;
    end
  end

  assign test_wr = wr_reg;
  assign test_rd = rd_reg;
  assign wr_data = data_reg;
endmodule

// ---- rtl/ifm_exit_detect.sv ----
// Power-on reset exit-pin watcher
`timescale 1ns/1ps
module ifm_exit_detect (
  input  wire logic clk,
  input  wire logic por_active,
  input  wire logic exit_pin,
  output logic      exit_req
);
  // Tracks whether the pin stayed high over the entire power-on reset
  logic in_por_reg, in_por_next;
  logic held_reg, held_next;
  logic req_reg, req_next;

  always_comb begin
    in_por_next = por_active;
    held_next   = held_reg;
    req_next    = 1'b0;
    if (por_active && !in_por_reg) begin
      held_next = exit_pin;
    end else if (por_active) begin
      held_next = held_reg & exit_pin;
    end
    if (!por_active && in_por_reg) begin
      req_next = held_reg;
    end
  end

  // Not reset by por_active itself; it watches that very reset
  always_ff @(posedge clk) begin
    in_por_reg <= in_por_next;
    held_reg   <= held_next;
    req_reg    <= req_next;
  end

  assign exit_req = req_reg;
endmodule

// ---- rtl/ifm_mode_ctrl.sv ----
// Programming-port mode control and status registers
`timescale 1ns/1ps
`include "ifm_regs.svh"
module ifm_mode_ctrl
  import ifm_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire logic       POR_ACTIVE,
  input  wire logic       BROWNOUT,
  input  wire logic       ICP_EXIT_PIN,
  input  wire logic       CTL_WR,
  input  wire logic [7:0] CTL_WDATA,
  input  wire logic       STAT_WR,
  input  wire logic [7:0] STAT_WDATA,
  input  wire logic [7:0] OPTION_BYTE1_SHADOW,
  input  wire logic       FLASH_OP_START,
  input  wire logic       FLASH_OP_DONE,
  input  wire logic       RX_VALID,
  input  wire logic [7:0] RX_BYTE,
  output logic            IN_CIRCUIT_PORT_ACTIVE,
  output logic [7:0]      ICP_MODE_CONTROL,
  output logic [7:0]      ICP_STATE_REPORT,
  output logic            CONTROLLER_BYPASS,
  output logic            TX_VALID,
  output logic [7:0]      TX_BYTE
);
  // Positions of the two protect bits inside the option byte shadow
  localparam int PROT1_SRC = 0;
  localparam int RWP_SRC   = 1;

  logic       test_wr, test_rd;
  logic [7:0] test_wdata;
  logic       exit_req;

  // ==========================================
  // Submodules
  ifm_cmd_decode u_dec (
    .clk     (CLK),
    .reset_n (RESET_N),
    .rx_valid(RX_VALID),
    .rx_byte (RX_BYTE),
    .test_wr (test_wr),
    .test_rd (test_rd),
    .wr_data (test_wdata)
  );

  ifm_exit_detect u_exit (
    .clk       (CLK),
    .por_active(POR_ACTIVE),
    .exit_pin  (ICP_EXIT_PIN),
    .exit_req  (exit_req)
  );

  // ==========================================
  // Register state
  logic       icp_reg, icp_next;
  logic [7:0] ctl_reg, ctl_next;
  logic [7:0] stat_reg, stat_next;
  logic [7:0] test_reg, test_next;
  logic       busy_reg, busy_next;
  logic       txv_reg, txv_next;
  logic [7:0] txb_reg, txb_next;

  always_comb begin
    icp_next  = icp_reg;
    ctl_next  = ctl_reg;
    test_next = test_reg;
    busy_next = busy_reg;
    txv_next  = 1'b0;
    txb_next  = txb_reg;
    if (CTL_WR) begin
      // Only the mode bit stores; ones in 6:0 are dropped
      ctl_next = {CTL_WDATA[`IFM_CTL_MODE_BIT], 7'h00};
    end
    if (test_wr) begin
      test_next = test_wdata & `IFM_TEST_RD_MASK;
    end
    if (test_rd) begin
      txv_next = 1'b1;
      txb_next = test_reg;
    end
    // Start beats done so a back-to-back start is not lost
    if (FLASH_OP_DONE) begin
      busy_next = 1'b0;
    end
    if (FLASH_OP_START) begin
      busy_next = 1'b1;
    end
    if (exit_req || BROWNOUT) begin
      icp_next  = 1'b0;
      ctl_next  = 8'h00;
      test_next = `IFM_TEST_RESET;
    end
    stat_next = 8'h00;
    stat_next[`IFM_STAT_MODE_BIT]  = ctl_next[`IFM_CTL_MODE_BIT];
    stat_next[`IFM_STAT_PROT1_BIT] = OPTION_BYTE1_SHADOW[PROT1_SRC];
    stat_next[`IFM_STAT_RWP_BIT]   = OPTION_BYTE1_SHADOW[RWP_SRC];
    stat_next[`IFM_STAT_BUSY_BIT]  = busy_next;
  end

  // Brownout also clears test mode; port entry comes only from RESET_N, which loads icp_reg with 1
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      icp_reg  <= 1'b1;
      ctl_reg  <= `IFM_CTL_RESET;
      stat_reg <= `IFM_STAT_RESET;
      test_reg <= `IFM_TEST_RESET;
      busy_reg <= 1'b0;
      txv_reg  <= 1'b0;
      txb_reg  <= 8'h00;
    end else begin
      icp_reg  <= icp_next;
      ctl_reg  <= ctl_next;
      stat_reg <= stat_next;
      test_reg <= test_next;
      busy_reg <= busy_next;
      txv_reg  <= txv_next;
      txb_reg  <= txb_next;
    end
  end

  assign IN_CIRCUIT_PORT_ACTIVE = icp_reg;
  assign ICP_MODE_CONTROL       = ctl_reg;
  assign ICP_STATE_REPORT       = stat_reg;
  assign CONTROLLER_BYPASS      = test_reg[`IFM_TEST_BYPASS_BIT];
  assign TX_VALID               = txv_reg;
  assign TX_BYTE                = txb_reg;

  // ==========================================
  // Checks
  chk_mode_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    CTL_WR && !BROWNOUT && !exit_req |=> ICP_MODE_CONTROL[7] == $past(CTL_WDATA[7]))
    else $error("Mode bit did not follow write");
  chk_ctl_low_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    ICP_MODE_CONTROL[6:0] == 7'h00)
    else $error("Control low bits not zero");
  chk_stat_mode: assert property (@(posedge CLK) disable iff (!RESET_N)
    ICP_STATE_REPORT[7] == ICP_MODE_CONTROL[7])
    else $error("Status mode bit mismatch");
  chk_stat_prot: assert property (@(posedge CLK) disable iff (!RESET_N)
    ##1 ICP_STATE_REPORT[6] == $past(OPTION_BYTE1_SHADOW[0]))
    else $error("Protect bit not shown");
  chk_stat_rwp: assert property (@(posedge CLK) disable iff (!RESET_N)
    ##1 ICP_STATE_REPORT[5] == $past(OPTION_BYTE1_SHADOW[1]))
    else $error("Read/write protect bit not shown");
  chk_busy_set: assert property (@(posedge CLK) disable iff (!RESET_N)
    FLASH_OP_START |=> ICP_STATE_REPORT[3])
    else $error("Busy not set on start");
  chk_busy_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
    FLASH_OP_DONE && !FLASH_OP_START |=> !ICP_STATE_REPORT[3])
    else $error("Busy not cleared on done");
  chk_test_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    RX_VALID && RX_BYTE == 8'hF0 && u_dec.state_reg == IFM_IDLE ##1 !RX_VALID ##1
    RX_VALID ##1 !BROWNOUT && !exit_req |=>
    CONTROLLER_BYPASS == $past(RX_BYTE[2], 2))
    else $error("Test write not stored");
  chk_test_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    RX_VALID && RX_BYTE == 8'hF1 && u_dec.state_reg == IFM_IDLE |=>
    ##1 TX_VALID && TX_BYTE == $past(test_reg))
    else $error("Test read not answered");
  chk_test_resv: assert property (@(posedge CLK) disable iff (!RESET_N)
    (test_reg & 8'hFB) == 8'h00)
    else $error("Test reserved bits nonzero");
  chk_brownout: assert property (@(posedge CLK) disable iff (!RESET_N)
    BROWNOUT |=> !IN_CIRCUIT_PORT_ACTIVE && !ICP_MODE_CONTROL[7])
    else $error("Brownout did not exit");
  chk_por_exit: assert property (@(posedge CLK) disable iff (!RESET_N)
    exit_req |=> !IN_CIRCUIT_PORT_ACTIVE && !ICP_MODE_CONTROL[7] && !CONTROLLER_BYPASS)
    else $error("Power-on exit did not leave mode");
  chk_stat_nowr: assert property (@(posedge CLK) disable iff (!RESET_N)
    STAT_WR |=> (ICP_STATE_REPORT & 8'h17) == 8'h00)
    else $error("Status write had effect");

  cov_mode_on: cover property (@(posedge CLK) CTL_WR && CTL_WDATA[7]);
  cov_bypass: cover property (@(posedge CLK) test_wr && test_wdata[2]);
  cov_read: cover property (@(posedge CLK) TX_VALID);
  cov_busy: cover property (@(posedge CLK) FLASH_OP_START ##[1:20] FLASH_OP_DONE);
endmodule

// ---- dv/ifm_prog_model.sv ----
// Programmer-side link model for the mode control block
`timescale 1ns/1ps
`include "ifm_regs.svh"
module ifm_prog_model (
  input  wire logic       clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  int         tx_count;
  logic [7:0] tx_last;
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    tx_count = 0;
    tx_last  = 8'h00;
  end
  // ==========================================
  // Byte sender
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_byte  <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    // Stale byte inverted so a late sample never matches
    rx_byte  <= ~b;
  endtask
  // Reserved bits always sent as ones
  task automatic write_test(input logic bypass);
    send(`IFM_CMD_TEST_WR);
    send({5'h1F, bypass, 2'h3});
  endtask
  // ==========================================
  // Reply capture
  always @(posedge clk) begin
    if (tx_valid === 1'b1) begin
      tx_count <= tx_count + 1;
      tx_last  <= tx_byte;
    end
  end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the programming-port mode control block
`timescale 1ns/1ps
`include "ifm_regs.svh"
module tb_top;
  logic       CLK, CTL_WR, STAT_WR, BROWNOUT, FLASH_OP_DONE, FLASH_OP_START;
  logic       RESET_N = 1'b0, POR_ACTIVE = 1'b0, ICP_EXIT_PIN = 1'b0;
  logic       RX_VALID, IN_CIRCUIT_PORT_ACTIVE, CONTROLLER_BYPASS, TX_VALID;
  logic [4:0] pz = 5'h00;
  logic [7:0] wdata = 8'h00, OPTION_BYTE1_SHADOW = 8'h00;
  logic [7:0] RX_BYTE, ICP_MODE_CONTROL, ICP_STATE_REPORT, TX_BYTE;
  int         failures = 0;
  int         compares = 0;
  int         n;
  // Row: bypass bit written, expected test register readback
  logic [8:0] rows [4] = '{9'h000, 9'h104, 9'h104, 9'h000};
  assign {CTL_WR, STAT_WR, BROWNOUT, FLASH_OP_DONE, FLASH_OP_START} = pz;
  ifm_mode_ctrl i_dut (.CLK(CLK), .RESET_N(RESET_N), .POR_ACTIVE(POR_ACTIVE),
    .BROWNOUT(BROWNOUT), .ICP_EXIT_PIN(ICP_EXIT_PIN), .CTL_WR(CTL_WR), .CTL_WDATA(wdata),
    .STAT_WR(STAT_WR), .STAT_WDATA(wdata), .OPTION_BYTE1_SHADOW(OPTION_BYTE1_SHADOW),
    .FLASH_OP_START(FLASH_OP_START), .FLASH_OP_DONE(FLASH_OP_DONE), .RX_VALID(RX_VALID),
    .RX_BYTE(RX_BYTE), .IN_CIRCUIT_PORT_ACTIVE(IN_CIRCUIT_PORT_ACTIVE),
    .ICP_MODE_CONTROL(ICP_MODE_CONTROL), .ICP_STATE_REPORT(ICP_STATE_REPORT),
    .CONTROLLER_BYPASS(CONTROLLER_BYPASS), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE));
  ifm_prog_model i_prog (.clk(CLK), .tx_valid(TX_VALID), .tx_byte(TX_BYTE),
    .rx_valid(RX_VALID), .rx_byte(RX_BYTE));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // ==========================================
  // Helpers
  task automatic print_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
  endtask
  // One-cycle strobe; waits long enough for status to follow
  task automatic pulse(input logic [4:0] m, input logic [7:0] d);
    @(posedge CLK);
    pz    <= m;
    wdata <= d;
    tick(1);
    pz    <= 5'h00;
    tick(2);
    #1;
  endtask
  task automatic do_reset;
    @(posedge CLK);
    RESET_N <= 1'b0;
    tick(5);
    RESET_N <= 1'b1;
    tick(1);
    #1;
  endtask
  task automatic state_check(input logic [7:0] exp);
    check("state", {ICP_MODE_CONTROL[7], ICP_STATE_REPORT[7], CONTROLLER_BYPASS,
      IN_CIRCUIT_PORT_ACTIVE, 4'h0}, exp);
  endtask
  task automatic read_test(input logic [7:0] exp);
    n = i_prog.tx_count;
    i_prog.send(`IFM_CMD_TEST_RD);
    for (int k = 0; k < 8 && i_prog.tx_count == n; k++) @(posedge CLK);
    if (i_prog.tx_count == n) begin
      failures++;
      print_verdict();
    end
    tick(3);
    #1;
    check("readback", i_prog.tx_last, exp);
    check("reply count", 8'(i_prog.tx_count - n), 8'h01);
  endtask
  task automatic por(input logic drop);
    @(posedge CLK);
    POR_ACTIVE   <= 1'b1;
    ICP_EXIT_PIN <= 1'b1;
    tick(3);
    // Pin released mid-reset must not count as an exit request
    ICP_EXIT_PIN <= ~drop;
    tick(2);
    POR_ACTIVE   <= 1'b0;
    ICP_EXIT_PIN <= 1'b0;
    tick(4);
    #1;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    do_reset();
    check("ctl reset", ICP_MODE_CONTROL, 8'h00);
    check("stat reset", ICP_STATE_REPORT, 8'h00);
    check("flags reset", {5'h00, CONTROLLER_BYPASS, TX_VALID, IN_CIRCUIT_PORT_ACTIVE}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      i_prog.write_test(rows[i][8]);
      tick(3);
      #1;
      check("bypass", {7'h00, CONTROLLER_BYPASS}, {7'h00, rows[i][8]});
      read_test(rows[i][7:0]);
    end
    n = i_prog.tx_count;
    i_prog.send(8'h55);
    tick(6);
    #1;
    check("unknown cmd", 8'(i_prog.tx_count - n), 8'h00);
    pulse(5'h10, 8'hFF);
    check("ctl on", ICP_MODE_CONTROL, 8'h80);
    check("stat on", ICP_STATE_REPORT, 8'h80);
    check("bypass via ctl", {7'h00, CONTROLLER_BYPASS}, 8'h00);
    pulse(5'h08, 8'hFF);
    check("stat write", ICP_STATE_REPORT, 8'h80);
    pulse(5'h10, 8'h7F);
    check("ctl off", ICP_MODE_CONTROL, 8'h00);
    check("stat off", ICP_STATE_REPORT, 8'h00);
    for (int s = 0; s < 4; s++) begin
      @(posedge CLK);
      OPTION_BYTE1_SHADOW <= {6'h3F, 2'(s)};
      tick(3);
      #1;
      check("protect", ICP_STATE_REPORT, {1'b0, s[0], s[1], 5'h00});
    end
    @(posedge CLK);
    OPTION_BYTE1_SHADOW <= 8'h00;
    pulse(5'h01, 8'h00);
    check("busy set", ICP_STATE_REPORT, 8'h08);
    pulse(5'h02, 8'h00);
    check("busy clear", ICP_STATE_REPORT, 8'h00);
    pulse(5'h03, 8'h00);
    check("busy start wins", ICP_STATE_REPORT, 8'h08);
    pulse(5'h02, 8'h00);
    check("busy clear again", ICP_STATE_REPORT, 8'h00);
    pulse(5'h10, 8'hFF);
    i_prog.write_test(1'b1);
    tick(3);
    #1;
    state_check(8'hF0);
    do_reset();
    state_check(8'h10);
    pulse(5'h10, 8'hFF);
    i_prog.write_test(1'b1);
    pulse(5'h04, 8'h00);
    state_check(8'h00);
    do_reset();
    pulse(5'h10, 8'hFF);
    i_prog.write_test(1'b1);
    por(1'b1);
    state_check(8'hF0);
    por(1'b0);
    state_check(8'h00);
    print_verdict();
  end
endmodule
